// file: design/fra_pkg.sv
/*
 * Shared constants and carrier types of the frame register access engine.
 * Assumes one 10 MHz system clock and 32-bit command words.
 */
package fra_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int PAUSE_UNIT_NS = 1000;
   localparam int US_CYCLES = (PAUSE_UNIT_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   localparam int US_DIV_W = 4;

   // ------------------------------------------------------------
   // command word layout
   // ------------------------------------------------------------
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_RMW = 2'h3;
   localparam logic [1:0] OP_CODE = 2'h0;
   localparam logic [3:0] CODE_IDLE = 4'h0;
   localparam logic [3:0] CODE_PAUSE = 4'h4;
   localparam int PAUSE_W = 28;
   localparam int PAUSE_LSB = 4;
   localparam int ADDR_LSB = 2;

   // ------------------------------------------------------------
   // response framing
   // ------------------------------------------------------------
   localparam int MIN_RSP_WORDS = 10;
   localparam int MCAST_BIT = 40;
   localparam int PORT_W = 4;

   typedef struct packed {
      logic last;
      logic [31:0] data;
   } fra_word_t;

   typedef struct packed {
      logic [47:0] dmac;
      logic [47:0] smac;
      logic [PORT_W-1:0] port;
   } fra_hdr_t;

   typedef struct packed {
      logic [29:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fra_bus_t;

endpackage

// file: design/fra_engine.sv
/*
 * Frame register access engine: executes the command words of one
 * request frame in order, drives the internal register bus and emits
 * the response words, zero padding and the swapped response header.
 * Assumes a framer upstream that strips the protocol header and marks
 * the last command word, and a framer downstream that builds the frame.
 */
module fra_engine #(
   parameter int MIN_WORDS = fra_pkg::MIN_RSP_WORDS,
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire fra_pkg::fra_word_t cmd_word,
   input wire fra_pkg::fra_hdr_t req_hdr,
   output fra_pkg::fra_bus_t bus,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_ack,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [31:0] rsp_data,
   output logic rsp_end,
   output fra_pkg::fra_hdr_t rsp_hdr,
   output logic busy
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [8:0] {
      S_CMD = 9'h001,
      S_DATA = 9'h002,
      S_MASK = 9'h004,
      S_RD = 9'h008,
      S_WR = 9'h010,
      S_PAUSE = 9'h020,
      S_OUT = 9'h040,
      S_PAD = 9'h080,
      S_END = 9'h100
   } fra_state_t;

   fra_state_t state;
   fra_state_t next_state;
   fra_state_t after_cmd;
   logic in_frame;
   logic last_seen;
   logic is_rmw;
   logic [31:0] wdata;
   logic [31:0] mask;
   logic [fra_pkg::PAUSE_W-1:0] pause_cnt;
   logic [fra_pkg::US_DIV_W-1:0] us_div;
   logic [CNT_W-1:0] rsp_cnt;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire cmd_take = cmd_valid && cmd_ready;
   wire [1:0] op = cmd_word.data[1:0];
   wire [3:0] code = cmd_word.data[3:0];
   wire op_rd = op == fra_pkg::OP_READ;
   wire op_wr = op == fra_pkg::OP_WRITE;
   wire op_rmw = op == fra_pkg::OP_RMW;
   wire op_idle = code == fra_pkg::CODE_IDLE;
   wire op_pause = code == fra_pkg::CODE_PAUSE;
   wire us_tick = us_div == fra_pkg::US_DIV_W'(fra_pkg::US_CYCLES - 1);
   wire pad_done = rsp_cnt >= CNT_W'(MIN_WORDS);
   wire rsp_take = rsp_valid && rsp_ready;
   wire [31:0] merged = (bus_rdata & ~mask) | (wdata & mask);

   assign cmd_ready = (state == S_CMD) || (state == S_DATA)
                      || (state == S_MASK);
   assign rsp_valid = (state == S_OUT) || (state == S_PAD && !pad_done);
   assign rsp_end = state == S_END;
   assign busy = in_frame;
   assign after_cmd = last_seen ? S_PAD : S_CMD;

   always_comb begin
      next_state = state;
      case (state)
         S_CMD: begin
            if (cmd_take) begin
               if (op_rd) begin
                  next_state = S_RD;
               end else if (op_wr || op_rmw) begin
                  next_state = S_DATA;
               end else if (op_idle) begin
                  next_state = S_OUT;
               end else if (op_pause) begin
                  next_state = S_PAUSE;
               end else begin
                  next_state = cmd_word.last ? S_PAD : S_CMD;
               end
            end
         end
         S_DATA: if (cmd_take) next_state = is_rmw ? S_MASK : S_WR;
         S_MASK: if (cmd_take) next_state = S_RD;
         S_RD: if (bus_ack) next_state = is_rmw ? S_WR : S_OUT;
         S_WR: if (bus_ack) next_state = after_cmd;
         S_PAUSE: if (pause_cnt == '0) next_state = after_cmd;
         S_OUT: if (rsp_take) next_state = after_cmd;
         S_PAD: if (pad_done) next_state = S_END;
         S_END: next_state = S_CMD;
         default: next_state = S_CMD;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) state <= sys_rst ? S_CMD : next_state;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         in_frame <= 1'b0;
         last_seen <= 1'b0;
         rsp_hdr <= '0;
      end else if (state == S_END) begin
         in_frame <= 1'b0;
         last_seen <= 1'b0;
      end else if (cmd_take) begin
         in_frame <= 1'b1;
         last_seen <= cmd_word.last;
         if (!in_frame) begin
            rsp_hdr.dmac <= req_hdr.smac;
            rsp_hdr.smac <= req_hdr.dmac
                            & ~(48'h1 << fra_pkg::MCAST_BIT);
            rsp_hdr.port <= req_hdr.port;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         is_rmw <= 1'b0;
         wdata <= '0;
         mask <= '0;
      end else if (cmd_take && state == S_CMD) begin
         is_rmw <= op_rmw;
      end else if (cmd_take && state == S_DATA) begin
         wdata <= cmd_word.data;
      end else if (cmd_take) begin
         mask <= cmd_word.data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus <= '0;
      end else if (next_state == S_RD && state != S_RD) begin
         bus.rd <= 1'b1;
         if (state == S_CMD) begin
            bus.addr <= cmd_word.data[31:fra_pkg::ADDR_LSB];
         end
      end else if (state == S_CMD && cmd_take) begin
         bus.addr <= cmd_word.data[31:fra_pkg::ADDR_LSB];
      end else if (state == S_DATA && next_state == S_WR) begin
         bus.wr <= 1'b1;
         bus.wdata <= cmd_word.data;
      end else if (state == S_RD && next_state == S_WR) begin
         bus.rd <= 1'b0;
         bus.wr <= 1'b1;
         bus.wdata <= merged;
      end else if (bus_ack) begin
         bus.rd <= 1'b0;
         bus.wr <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pause_cnt <= '0;
         us_div <= '0;
      end else if (state == S_CMD && next_state == S_PAUSE) begin
         pause_cnt <= cmd_word.data[31:fra_pkg::PAUSE_LSB];
         us_div <= '0;
      end else if (state == S_PAUSE) begin
         us_div <= us_tick ? '0 : us_div + 1'b1;
         if (us_tick && pause_cnt != '0) pause_cnt <= pause_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_data <= '0;
         rsp_cnt <= '0;
      end else begin
         if (state == S_CMD && next_state == S_OUT) begin
            rsp_data <= cmd_word.data;
         end else if (state == S_RD && next_state == S_OUT) begin
            rsp_data <= bus_rdata;
         end else if (next_state == S_PAD) begin
            rsp_data <= '0;
         end
         if (state == S_END) begin
            rsp_cnt <= '0;
         end else if (rsp_take && !(&rsp_cnt)) begin
            rsp_cnt <= rsp_cnt + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   wire take_cmd = cmd_take && state == S_CMD;

   property p_write_len;
      @(posedge clk) disable iff (sys_rst)
      take_cmd && op_wr |=> state == S_DATA && !is_rmw && cmd_ready;
   endproperty
   a_write_len: assert property (p_write_len)
      else $error("write did not wait for its data word");
   property p_write_full;
      @(posedge clk) disable iff (sys_rst)
      state == S_DATA && cmd_take && !is_rmw |=>
         bus.wr && bus.wdata == $past(cmd_word.data);
   endproperty
   a_write_full: assert property (p_write_full)
      else $error("write data not stored whole");
   property p_rmw_decode;
      @(posedge clk) disable iff (sys_rst)
      take_cmd && op_rmw |=> state == S_DATA && is_rmw;
   endproperty
   a_rmw_decode: assert property (p_rmw_decode)
      else $error("rmw not decoded");
   property p_rmw_merge;
      @(posedge clk) disable iff (sys_rst)
      state == S_RD && bus_ack && is_rmw |=> bus.wr
         && bus.wdata == (($past(bus_rdata) & ~mask) | (wdata & mask));
   endproperty
   a_rmw_merge: assert property (p_rmw_merge)
      else $error("rmw merge wrong");
   property p_idle_echo;
      @(posedge clk) disable iff (sys_rst)
      take_cmd && op == fra_pkg::OP_CODE && op_idle |=>
         rsp_valid && rsp_data == $past(cmd_word.data) && !bus.rd && !bus.wr;
   endproperty
   a_idle_echo: assert property (p_idle_echo)
      else $error("idle not echoed");
   property p_pause_one;
      @(posedge clk) disable iff (sys_rst)
      take_cmd && op_pause
         && cmd_word.data[31:fra_pkg::PAUSE_LSB] == fra_pkg::PAUSE_W'(1) |=>
         (state == S_PAUSE && !bus.rd && !bus.wr)[*8]
         ##1 (state == S_PAUSE)[*3] ##1 state != S_PAUSE;
   endproperty
   a_pause_one: assert property (p_pause_one)
      else $error("one microsecond pause wrong length");
   property p_read_addr;
      @(posedge clk) disable iff (sys_rst)
      take_cmd && op_rd |=> bus.rd && bus.addr == $past(cmd_word.data[31:2]);
   endproperty
   a_read_addr: assert property (p_read_addr)
      else $error("read not issued");
   property p_serial;
      @(posedge clk) disable iff (sys_rst)
      (bus.rd || bus.wr) |-> !cmd_ready && !rsp_valid;
   endproperty
   a_serial: assert property (p_serial)
      else $error("command overlapped a bus access");
   property p_swap;
      @(posedge clk) disable iff (sys_rst)
      rsp_end |-> !rsp_hdr.smac[fra_pkg::MCAST_BIT];
   endproperty
   a_swap: assert property (p_swap)
      else $error("multicast bit left in source");
   property p_pad;
      @(posedge clk) disable iff (sys_rst)
      rsp_end |-> rsp_cnt >= CNT_W'(MIN_WORDS);
   endproperty
   a_pad: assert property (p_pad)
      else $error("response shorter than minimum");

   c_rmw: cover property (@(posedge clk) state == S_RD && is_rmw && bus_ack);
   c_pause: cover property (@(posedge clk) state == S_PAUSE && us_tick);
   c_end: cover property (@(posedge clk) rsp_end);

endmodule

// file: tb/fra_reg_model.sv
/*
 * Register space behind the engine's internal bus, with a variable
 * acknowledge delay. Assumes rd/wr held until the edge after bus_ack.
 */
module fra_reg_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire fra_pkg::fra_bus_t bus,
   input wire logic [3:0] lat,
   output logic [31:0] bus_rdata,
   output logic bus_ack,
   output int n_acc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [16];
   logic [31:0] last_rd;
   logic [3:0] wait_cnt;
   wire req = bus.rd | bus.wr;

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = {8{4'(i)}};
      end
      last_rd = 32'h0;
   end

   // --------------------------------------------------------------
   // one access at a time, acked after lat cycles
   // --------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         bus_ack <= 1'b0;
         wait_cnt <= lat;
         n_acc <= 0;
      end else if (bus_ack) begin
         bus_ack <= 1'b0;
         wait_cnt <= lat;
      end else if (req && wait_cnt != 4'h0) begin
         wait_cnt <= wait_cnt - 4'h1;
      end else if (req) begin
         bus_ack <= 1'b1;
         n_acc <= n_acc + 1;
         last_rd <= mem[bus.addr[3:0]];
         if (bus.wr) mem[bus.addr[3:0]] <= bus.wdata;
      end
   end

   // read data is only meaningful with the ack
   assign bus_rdata = bus_ack ? last_rd : ~last_rd;
endmodule

// file: tb/tb_frame_register_access_engine.sv
/*
 * Self-checking bench of the frame register access engine.
 * Assumes the register model on the bus and a 10 MHz clock.
 */
module tb_frame_register_access_engine;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MINW = 4;
   logic clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
   logic rsp_end, busy, bus_ack;
   logic [31:0] bus_rdata, rsp_data, rng;
   logic [3:0] lat;
   fra_pkg::fra_word_t cmd_word;
   fra_pkg::fra_hdr_t req_hdr, rsp_hdr, exp_hdr;
   fra_pkg::fra_bus_t bus;
   int n_fail, num_checks, cyc, exp_acc, t_take, n_acc;
   logic [31:0] shadow [16];
   logic [31:0] got [$];
   logic [31:0] exp [$];
   fra_pkg::fra_word_t cmds [$];
   int pz [$];

   fra_engine #(.MIN_WORDS(MINW)) dut (.clk(clk), .sys_rst(sys_rst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
      .req_hdr(req_hdr), .bus(bus), .bus_rdata(bus_rdata),
      .bus_ack(bus_ack), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_data(rsp_data), .rsp_end(rsp_end), .rsp_hdr(rsp_hdr),
      .busy(busy));
   fra_reg_model regs (.clk(clk), .sys_rst(sys_rst), .bus(bus),
      .lat(lat), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .n_acc(n_acc));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   function automatic void nxt(output logic [31:0] v);
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      v = rng;
   endfunction

   // masked bits from the new data, the rest kept
   function automatic logic [31:0] rmw_exp(input logic [31:0] o,
      input logic [31:0] d, input logic [31:0] m);
      return (o & ~m) | (d & m);
   endfunction

   task automatic chk(input logic [99:0] g, input logic [99:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wrap_up();
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic put(input logic [31:0] w, input int p);
      cmds.push_back('{last: 1'b0, data: w});
      pz.push_back(p);
   endtask

   // appends one command and its expected effects
   task automatic add(input int k, input bit fix);
      logic [31:0] a, d, m;
      logic [1:0] pn;
      nxt(a);
      nxt(d);
      nxt(m);
      pn = fix ? 2'h1 : a[1:0];
      if (fix) a[5:2] = 4'h3;
      case (k)
         0: begin
            put({a[31:2], fra_pkg::OP_READ}, -1);
            exp.push_back(shadow[a[5:2]]);
            exp_acc++;
         end
         1: begin
            put({a[31:2], fra_pkg::OP_WRITE}, -1);
            put(d, -1);
            shadow[a[5:2]] = d;
            exp_acc++;
         end
         2: begin
            put({a[31:2], fra_pkg::OP_RMW}, -1);
            put(d, -1);
            put(m, -1);
            shadow[a[5:2]] = rmw_exp(shadow[a[5:2]], d, m);
            exp_acc += 2;
         end
         3: begin
            put({d[31:4], fra_pkg::CODE_IDLE}, -1);
            exp.push_back({d[31:4], fra_pkg::CODE_IDLE});
         end
         4: put({d[31:4], 4'h8}, -1);
         default: put({26'h0, pn, fra_pkg::CODE_PAUSE}, int'(pn));
      endcase
   endtask

   task automatic send(input fra_pkg::fra_word_t w);
      int n;
      cmd_valid = 1'b1;
      cmd_word = w;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      chk(cmd_ready, 1'b1);
      t_take = cyc;
      @(negedge clk);
   endtask

   task automatic run_req();
      logic [31:0] r;
      int n, pv, lo;
      @(negedge clk);
      nxt(r);
      req_hdr.dmac = {r[15:0], r};
      nxt(r);
      req_hdr.smac = {r, r[31:16]};
      req_hdr.port = r[3:0];
      exp_hdr.dmac = req_hdr.smac;
      exp_hdr.smac = req_hdr.dmac;
      exp_hdr.smac[fra_pkg::MCAST_BIT] = 1'b0;
      exp_hdr.port = req_hdr.port;
      cmds[cmds.size() - 1].last = 1'b1;
      for (int i = 0; i < cmds.size(); i++) begin
         pv = t_take;
         send(cmds[i]);
         if (i > 0 && pz[i - 1] >= 0) begin
            lo = fra_pkg::US_CYCLES * pz[i - 1] + 1;
            chk(t_take - pv >= lo && t_take - pv <= lo + 3, 1);
         end
      end
      cmd_valid = 1'b0;
      chk(busy, 1'b1);
      while (exp.size() < MINW) exp.push_back(32'h0);
      n = 0;
      #2;
      while (rsp_end !== 1'b1 && n < 5000) begin
         @(negedge clk);
         #2;
         n++;
      end
      chk(rsp_end, 1'b1);
      chk(rsp_hdr, exp_hdr);
      chk(got.size(), exp.size());
      for (int i = 0; i < exp.size() && i < got.size(); i++) begin
         chk(got[i], exp[i]);
      end
      chk(n_acc, exp_acc);
      got.delete();
      exp.delete();
      cmds.delete();
      pz.delete();
   endtask

   // response sink with random back-pressure
   always @(negedge clk) begin
      logic [31:0] r;
      nxt(r);
      rsp_ready = r[0] | r[1];
      lat = r[7:4];
      #1;
      if (rsp_valid === 1'b1 && rsp_ready) got.push_back(rsp_data);
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      logic [31:0] r;
      int nc;
      rng = 32'h52;
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_word = '0;
      req_hdr = '0;
      rsp_ready = 1'b0;
      lat = 4'h0;
      {n_fail, num_checks, cyc, exp_acc, t_take} = '0;
      for (int i = 0; i < 16; i++) shadow[i] = {8{4'(i)}};
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      chk({busy, cmd_ready, rsp_valid}, 3'h2);
      add(3, 1'b0);
      run_req();
      add(1, 1'b1);
      add(2, 1'b1);
      add(0, 1'b1);
      add(5, 1'b1);
      add(0, 1'b1);
      run_req();
      add(4, 1'b0);
      add(5, 1'b0);
      add(3, 1'b0);
      run_req();
      for (int q = 0; q < 30; q++) begin
         nxt(r);
         nc = 1 + int'(r[2:0] % 3'h6);
         for (int j = 0; j < nc; j++) begin
            nxt(r);
            add(int'(r[2:0] % 3'h6), 1'b0);
         end
         run_req();
      end
      wrap_up();
   end

   initial begin
      #3000000;
      n_fail++;
      wrap_up();
   end
endmodule
